// ===== common/isa_pkg.sv
/*
  constants shared by the bus glue end, the graphics device end and the link interface.
  assumes a single 40 mhz core clock for both ends; bus pins are sampled synchronously.
*/
// Functional notes
// RULE1: glue selects window for address bits 0000101.
// RULE2: glue qualifies memory strobes with window select.
// RULE3: glue drives 16-bit select only inside window.
// RULE4: bus reset resets device and serial enables.
// RULE5: refresh cycle blocks display memory access.
// RULE6: upper byte enable adds high byte.
// RULE7: io strobes count only with address enable low.
// RULE8: vsync raises frame interrupt, programmable polarity.
// RULE9: rewriting timing register 11h clears interrupt.
// RULE10: ready low for waits, high, then released.
// RULE11: device decodes low address, glue the rest.
// RULE12: window is legacy video range a0000-bffff.
// RULE13: ready released unless device is the target.
package isa_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 16;
  localparam int UPPER_W = 7;
  // upper address bits 23..17, window pattern 23..20 low, 19 high, 18 low, 17 high
  localparam logic [UPPER_W-1:0] WIN_UPPER_MATCH = 7'h05;
  localparam logic [23:0] WIN_BASE = 24'h0a0000;
  localparam logic [23:0] WIN_LAST = 24'h0bffff;
  // io ports of the display timing controller and the interrupt control port
  localparam logic [ADDR_W-1:0] PORT_TIM_INDEX = 17'h003d4;
  localparam logic [ADDR_W-1:0] PORT_TIM_DATA = 17'h003d5;
  localparam logic [ADDR_W-1:0] PORT_IRQ_CTRL = 17'h003d6;
  localparam logic [7:0] TIM_IDX_VRETRACE_END = 8'h11;
  localparam int IRQ_CTRL_EN_BIT = 0;
  localparam int IRQ_CTRL_POL_BIT = 1;
  localparam logic [7:0] IRQ_CTRL_RESET = 8'h02;
  localparam logic [7:0] TIM_RESET = 8'h00;
  // io cycles are stretched by a fixed wait, memory cycles until the memory answers
  localparam int CLK_PERIOD_PS = 25000;
  localparam int IO_WAIT_NS = 100;
  localparam int IO_WAIT_CYCLES = (IO_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WAIT_W = 8;
endpackage

// ===== common/isa_link_if.sv
/*
  link between the bus glue end and the graphics device end.
  assumes both ends share core_clk; shared pins are resolved here from output enables.
*/
`timescale 1ns/1ps
interface isa_link_if;
  import isa_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic qualified_mem_read_n;
  logic qualified_mem_write_n;
  logic io_read_n;
  logic io_write_n;
  logic aen;
  logic upper_byte_enable_n;
  logic refresh_cycle_n;
  logic bus_reset;
  logic memcs16_o;
  logic memcs16_oe;
  logic [DATA_W-1:0] host_data_o;
  logic host_data_oe;
  logic [DATA_W-1:0] dev_data_o;
  logic dev_data_oe;
  logic rdy_o;
  logic rdy_oe;
  logic irq;
  // resolved wire levels: ready has a pull-up, memcs16 is undriven low outside the window
  logic rdy;
  logic memcs16;
  logic [DATA_W-1:0] data;
  assign rdy = rdy_oe ? rdy_o : 1'b1;
  assign memcs16 = memcs16_oe & memcs16_o;
  assign data = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 16'hffff);

  modport glue (
    output addr, qualified_mem_read_n, qualified_mem_write_n, io_read_n, io_write_n, aen,
    output upper_byte_enable_n, refresh_cycle_n, bus_reset, memcs16_o, memcs16_oe,
    output host_data_o, host_data_oe,
    input rdy, irq, data
  );
  modport dev (
    input addr, qualified_mem_read_n, qualified_mem_write_n, io_read_n, io_write_n, aen,
    input upper_byte_enable_n, refresh_cycle_n, bus_reset, data,
    output dev_data_o, dev_data_oe, rdy_o, rdy_oe, irq
  );
endinterface

// ===== hw/wait_timer.sv
/*
  down counter that times the fixed wait of an io cycle.
  assumes load is a one-cycle pulse; done is high whenever the count is zero.
*/
`timescale 1ns/1ps
module wait_timer
  import isa_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic [WAIT_W-1:0] count_in,
  output logic done
);
  logic [WAIT_W-1:0] cnt_r;
  logic [WAIT_W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = count_in;
    end else if (cnt_r != 8'h00) begin
      cnt_nxt = cnt_r - 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign done = (cnt_r == 8'h00);
endmodule // wait_timer

// ===== hw/isa_gfx_dev.sv
/*
  graphics device end of the bus: qualified memory and io cycles, wait states on ready,
  io registers of the timing controller and the frame interrupt.
  assumes the glue end has already qualified memory strobes with the upper address and
  that display memory sits behind the mem_* request/acknowledge port.
*/
`timescale 1ns/1ps
module isa_gfx_dev
  import isa_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  isa_link_if.dev bus,
  input wire logic vsync,
  output logic mem_req,
  output logic mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [1:0] mem_be,
  output logic [DATA_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [DATA_W-1:0] mem_rdata,
  output logic vram_serial_oe_n
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_MEM = 3'b001,
    ST_IO = 3'b010,
    ST_END = 3'b011,
    ST_HOLD = 3'b100
  } cyc_state_t;

  cyc_state_t state_r, state_nxt;
  logic mem_req_r, mem_req_nxt;
  logic mem_we_r, mem_we_nxt;
  logic [ADDR_W-1:0] mem_addr_r, mem_addr_nxt;
  logic [1:0] mem_be_r, mem_be_nxt;
  logic [DATA_W-1:0] mem_wdata_r, mem_wdata_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic dout_oe_r, dout_oe_nxt;
  logic rdy_r, rdy_nxt;
  logic rdy_oe_r, rdy_oe_nxt;
  logic [7:0] tim_index_r, tim_index_nxt;
  logic [7:0] tim_vre_r, tim_vre_nxt;
  logic [7:0] irq_ctrl_r, irq_ctrl_nxt;
  logic irq_pend_r, irq_pend_nxt;
  logic irq_r, irq_nxt;
  logic vsync_r;
  logic soe_n_r;
  logic timer_load;
  logic timer_done;
  logic mem_go;
  logic io_go;
  logic io_rd;
  logic io_wr;
  logic strobes_idle;
  logic port_hit;
  logic vsync_rise;
  logic clear_irq;

  // byte lanes of a word access: low lane by a0, high lane by the upper byte enable
  function automatic logic [1:0] lanes(input logic a0, input logic ube_n);
    lanes = {~ube_n, ~a0};
  endfunction

  // only the low address is decoded here; the window is the glue's job
  function automatic logic is_our_port(input logic [ADDR_W-1:0] a);
    is_our_port = (a == PORT_TIM_INDEX) || (a == PORT_TIM_DATA) || (a == PORT_IRQ_CTRL);
  endfunction

  assign port_hit = is_our_port(bus.addr); // [RULE11]
  assign io_rd = !bus.aen && !bus.io_read_n; // [RULE7]
  assign io_wr = !bus.aen && !bus.io_write_n; // [RULE7]
  assign io_go = port_hit && (io_rd || io_wr);
  assign mem_go = bus.refresh_cycle_n && // [RULE5]
                  (!bus.qualified_mem_read_n || !bus.qualified_mem_write_n); // [RULE2]
  assign strobes_idle = bus.qualified_mem_read_n && bus.qualified_mem_write_n &&
                        bus.io_read_n && bus.io_write_n;
  assign vsync_rise = vsync && !vsync_r;
  assign clear_irq = (state_r == ST_IDLE) && io_go && io_wr &&
                     (bus.addr == PORT_TIM_DATA) && (tim_index_r == TIM_IDX_VRETRACE_END);

  wait_timer u_wait (
    .core_clk(core_clk),
    .rstn(rstn),
    .load(timer_load),
    .count_in(WAIT_W'(IO_WAIT_CYCLES)),
    .done(timer_done)
  );

  always_comb begin
    state_nxt = state_r;
    mem_req_nxt = 1'b0;
    mem_we_nxt = mem_we_r;
    mem_addr_nxt = mem_addr_r;
    mem_be_nxt = mem_be_r;
    mem_wdata_nxt = mem_wdata_r;
    dout_nxt = dout_r;
    dout_oe_nxt = dout_oe_r;
    rdy_nxt = rdy_r;
    rdy_oe_nxt = rdy_oe_r;
    tim_index_nxt = tim_index_r;
    tim_vre_nxt = tim_vre_r;
    irq_ctrl_nxt = irq_ctrl_r;
    timer_load = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        rdy_oe_nxt = 1'b0; // [RULE13]
        dout_oe_nxt = 1'b0;
        if (mem_go) begin
          state_nxt = ST_MEM;
          mem_req_nxt = 1'b1;
          mem_we_nxt = !bus.qualified_mem_write_n;
          mem_addr_nxt = bus.addr;
          mem_be_nxt = lanes(bus.addr[0], bus.upper_byte_enable_n); // [RULE6]
          mem_wdata_nxt = bus.data;
          rdy_nxt = 1'b0; // [RULE10]
          rdy_oe_nxt = 1'b1;
        end else if (io_go) begin
          state_nxt = ST_IO;
          timer_load = 1'b1;
          rdy_nxt = 1'b0; // [RULE10]
          rdy_oe_nxt = 1'b1;
          if (io_wr) begin
            if (bus.addr == PORT_TIM_INDEX) begin
              tim_index_nxt = bus.data[7:0];
            end else if (bus.addr == PORT_TIM_DATA) begin
              if (tim_index_r == TIM_IDX_VRETRACE_END) begin
                tim_vre_nxt = bus.data[7:0];
              end
            end else begin
              irq_ctrl_nxt = bus.data[7:0];
            end
          end else begin
            dout_oe_nxt = 1'b1;
            if (bus.addr == PORT_TIM_INDEX) begin
              dout_nxt = {8'h00, tim_index_r};
            end else if (bus.addr == PORT_TIM_DATA) begin
              dout_nxt = (tim_index_r == TIM_IDX_VRETRACE_END) ? {8'h00, tim_vre_r} : 16'h0000;
            end else begin
              dout_nxt = {8'h00, irq_ctrl_r};
            end
          end
        end
      end
      ST_MEM: begin
        if (mem_ack) begin
          state_nxt = ST_END;
          if (!mem_we_r) begin
            dout_nxt = mem_rdata;
            dout_oe_nxt = 1'b1;
          end
        end
      end
      ST_IO: begin
        if (timer_done) begin
          state_nxt = ST_END;
        end
      end
      ST_END: begin
        rdy_nxt = 1'b1; // [RULE10]
        state_nxt = ST_HOLD;
      end
      ST_HOLD: begin
        rdy_oe_nxt = 1'b0; // [RULE10]
        if (strobes_idle) begin
          dout_oe_nxt = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // bus reset is the master reset of the device
    if (bus.bus_reset) begin // [RULE4]
      state_nxt = ST_IDLE;
      mem_req_nxt = 1'b0;
      dout_oe_nxt = 1'b0;
      rdy_nxt = 1'b1;
      rdy_oe_nxt = 1'b0;
      tim_index_nxt = TIM_RESET;
      tim_vre_nxt = TIM_RESET;
      irq_ctrl_nxt = IRQ_CTRL_RESET;
    end
  end

  // a vsync edge in the same cycle as the clearing write keeps the interrupt pending
  always_comb begin
    irq_pend_nxt = irq_pend_r;
    if (clear_irq) begin
      irq_pend_nxt = 1'b0; // [RULE9]
    end
    if (vsync_rise && irq_ctrl_r[IRQ_CTRL_EN_BIT]) begin
      irq_pend_nxt = 1'b1; // [RULE8]
    end
    if (bus.bus_reset) begin
      irq_pend_nxt = 1'b0;
    end
    irq_nxt = irq_ctrl_nxt[IRQ_CTRL_POL_BIT] ? irq_pend_nxt : !irq_pend_nxt; // [RULE8]
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      mem_req_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_addr_r <= 17'h00000;
      mem_be_r <= 2'h0;
      mem_wdata_r <= 16'h0000;
      dout_r <= 16'h0000;
      dout_oe_r <= 1'b0;
      rdy_r <= 1'b1;
      rdy_oe_r <= 1'b0;
      tim_index_r <= TIM_RESET;
      tim_vre_r <= TIM_RESET;
      irq_ctrl_r <= IRQ_CTRL_RESET;
      irq_pend_r <= 1'b0;
      irq_r <= 1'b0;
      vsync_r <= 1'b0;
      soe_n_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      mem_req_r <= mem_req_nxt;
      mem_we_r <= mem_we_nxt;
      mem_addr_r <= mem_addr_nxt;
      mem_be_r <= mem_be_nxt;
      mem_wdata_r <= mem_wdata_nxt;
      dout_r <= dout_nxt;
      dout_oe_r <= dout_oe_nxt;
      rdy_r <= rdy_nxt;
      rdy_oe_r <= rdy_oe_nxt;
      tim_index_r <= tim_index_nxt;
      tim_vre_r <= tim_vre_nxt;
      irq_ctrl_r <= irq_ctrl_nxt;
      irq_pend_r <= irq_pend_nxt;
      irq_r <= irq_nxt;
      vsync_r <= vsync;
      soe_n_r <= bus.bus_reset; // [RULE4]
    end
  end

  assign mem_req = mem_req_r;
  assign mem_we = mem_we_r;
  assign mem_addr = mem_addr_r;
  assign mem_be = mem_be_r;
  assign mem_wdata = mem_wdata_r;
  assign vram_serial_oe_n = soe_n_r;
  assign bus.dev_data_o = dout_r;
  assign bus.dev_data_oe = dout_oe_r;
  assign bus.rdy_o = rdy_r;
  assign bus.rdy_oe = rdy_oe_r;
  assign bus.irq = irq_r;
endmodule // isa_gfx_dev

// ===== hw/isa_bus_glue.sv
/*
  bus side glue: decodes the upper latched address into the video window select, qualifies
  the memory strobes, drives the 16-bit memory select and passes the rest of the bus.
  assumes host bus pins are synchronous to core_clk; every pin is retimed by one flop.
*/
`timescale 1ns/1ps
module isa_bus_glue
  import isa_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  isa_link_if.glue bus,
  input wire logic [UPPER_W-1:0] host_la,
  input wire logic [ADDR_W-1:0] host_sa,
  input wire logic host_mem_read_n,
  input wire logic host_mem_write_n,
  input wire logic host_io_read_n,
  input wire logic host_io_write_n,
  input wire logic host_aen,
  input wire logic host_bhe_n,
  input wire logic host_refresh_n,
  input wire logic host_reset,
  input wire logic [DATA_W-1:0] host_wdata,
  input wire logic host_wdata_oe,
  output logic [DATA_W-1:0] host_rdata,
  output logic host_ready,
  output logic host_memcs16,
  output logic host_irq
);
  logic sel;
  logic [ADDR_W-1:0] addr_r;
  logic qmr_n_r, qmr_n_nxt;
  logic qmw_n_r, qmw_n_nxt;
  logic [3:0] ctl_r;
  logic sel_r;
  logic rst_r;
  logic [DATA_W-1:0] wd_r;
  logic wd_oe_r;
  logic [DATA_W-1:0] rd_r;
  logic rdy_r;
  logic irq_r;

  // window a0000..bffff from the upper latched address only
  assign sel = (host_la == WIN_UPPER_MATCH); // [RULE1] [RULE12]

  always_comb begin
    qmr_n_nxt = host_mem_read_n || !sel; // [RULE2]
    qmw_n_nxt = host_mem_write_n || !sel; // [RULE2]
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      addr_r <= 17'h00000;
      qmr_n_r <= 1'b1;
      qmw_n_r <= 1'b1;
      ctl_r <= 4'hf;
      sel_r <= 1'b0;
      rst_r <= 1'b1;
      wd_r <= 16'h0000;
      wd_oe_r <= 1'b0;
      rd_r <= 16'h0000;
      rdy_r <= 1'b1;
      irq_r <= 1'b0;
    end else begin
      addr_r <= host_sa; // [RULE11]
      qmr_n_r <= qmr_n_nxt;
      qmw_n_r <= qmw_n_nxt;
      ctl_r <= {host_io_read_n, host_io_write_n, host_bhe_n, host_refresh_n};
      sel_r <= sel; // [RULE3]
      rst_r <= host_reset; // [RULE4]
      wd_r <= host_wdata;
      wd_oe_r <= host_wdata_oe;
      rd_r <= bus.data;
      rdy_r <= bus.rdy;
      irq_r <= bus.irq;
    end
  end

  // aen has a flop of its own so it stays aligned with the io strobes
  logic aen_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      aen_r <= 1'b1;
    end else begin
      aen_r <= host_aen;
    end
  end

  assign bus.addr = addr_r;
  assign bus.qualified_mem_read_n = qmr_n_r;
  assign bus.qualified_mem_write_n = qmw_n_r;
  assign bus.io_read_n = ctl_r[3];
  assign bus.io_write_n = ctl_r[2];
  assign bus.upper_byte_enable_n = ctl_r[1];
  assign bus.refresh_cycle_n = ctl_r[0];
  assign bus.aen = aen_r;
  assign bus.bus_reset = rst_r;
  assign bus.memcs16_oe = sel_r; // [RULE3]
  assign bus.memcs16_o = 1'b1; // [RULE3]
  assign bus.host_data_o = wd_r;
  assign bus.host_data_oe = wd_oe_r;
  assign host_rdata = rd_r;
  assign host_ready = rdy_r;
  assign host_memcs16 = sel_r;
  assign host_irq = irq_r;
endmodule // isa_bus_glue

// ===== dv/isa_host_bus_slave_port_sva.sv
/*
  assertions on the link between the bus glue end and the graphics device end.
  assumes the bench places it beside the link interface; one clock, rstn low resets.
*/
`timescale 1ns/1ps
module isa_host_bus_slave_port_sva (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic qualified_mem_read_n,
  input wire logic qualified_mem_write_n,
  input wire logic io_read_n,
  input wire logic io_write_n,
  input wire logic aen,
  input wire logic refresh_cycle_n,
  input wire logic bus_reset,
  input wire logic memcs16_o,
  input wire logic memcs16_oe,
  input wire logic dev_data_oe,
  input wire logic rdy_o,
  input wire logic rdy_oe
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  chk_read_window: assert property (
    !qualified_mem_read_n |-> memcs16_oe) else $error("read strobe outside window");
  chk_write_window: assert property (
    !qualified_mem_write_n |-> memcs16_oe) else $error("write strobe outside window");
  chk_select_level: assert property (
    memcs16_oe |-> memcs16_o) else $error("memcs16 driven low");
  chk_refresh_block: assert property (
    !rdy_oe && !refresh_cycle_n && io_read_n && io_write_n |=> !rdy_oe)
    else $error("cycle taken during refresh");
  chk_io_invalid: assert property (
    !rdy_oe && aen && qualified_mem_read_n && qualified_mem_write_n |=> !rdy_oe)
    else $error("io strobe taken with aen high");
  chk_wait_start: assert property (
    $rose(rdy_oe) |-> !rdy_o) else $error("ready not low at cycle start");
  chk_ready_release: assert property (
    rdy_oe && rdy_o |=> !rdy_oe) else $error("ready not released after high");
  // io wait is the timer's 4 counts, its cycle at zero and the end state, so ready stays low six cycles
  chk_io_wait: assert property (
    $rose(rdy_oe) && qualified_mem_read_n && qualified_mem_write_n |-> !rdy_o[*6] ##1 rdy_o)
    else $error("io wait length wrong");
  chk_target_only: assert property (
    $rose(rdy_oe) |-> $past(!qualified_mem_read_n || !qualified_mem_write_n
      || (!aen && !(io_read_n && io_write_n)))) else $error("ready driven without a cycle");
  chk_bus_reset: assert property (
    bus_reset |=> !rdy_oe && !dev_data_oe) else $error("bus reset ignored");
endmodule // isa_host_bus_slave_port_sva

// ===== dv/isa_host_bus_slave_port_bench.sv
/*
  self-checking bench: glue and device joined by the link, host pins driven here.
  assumes one 40 mhz clock; the display memory port is answered by a responder here.
*/
`timescale 1ns/1ps
module isa_host_bus_slave_port_bench;
  import isa_pkg::*;
  logic core_clk, rstn, vsync, host_reset, mem_ack, took, qsel, csel, rf, wt;
  logic host_mem_read_n, host_mem_write_n, host_io_read_n, host_io_write_n;
  logic host_aen, host_bhe_n, host_refresh_n, host_wdata_oe;
  logic host_ready, host_memcs16, host_irq, mem_req, mem_we, vram_serial_oe_n;
  logic [UPPER_W-1:0] host_la, la;
  logic [ADDR_W-1:0] host_sa, mem_addr, sa;
  logic [DATA_W-1:0] host_wdata, host_rdata, mem_rdata, mem_wdata, seen, wd, hr;
  logic [1:0] mem_be, k;
  int seed = 29, mismatches = 0, cmp_count = 0, cycles = 0, reqs = 0, ack_wait = 0, i, r0;

  isa_link_if link();
  isa_bus_glue isa_bus_glue_inst (.core_clk, .rstn, .bus(link), .host_la, .host_sa,
    .host_mem_read_n, .host_mem_write_n, .host_io_read_n, .host_io_write_n, .host_aen,
    .host_bhe_n, .host_refresh_n, .host_reset, .host_wdata, .host_wdata_oe, .host_rdata,
    .host_ready, .host_memcs16, .host_irq);
  isa_gfx_dev isa_gfx_dev_inst (.core_clk, .rstn, .bus(link), .vsync, .mem_req, .mem_we,
    .mem_addr, .mem_be, .mem_wdata, .mem_ack, .mem_rdata, .vram_serial_oe_n);
  isa_host_bus_slave_port_sva isa_host_bus_slave_port_sva_inst (.core_clk, .rstn,
    .qualified_mem_read_n(link.qualified_mem_read_n),
    .qualified_mem_write_n(link.qualified_mem_write_n), .io_read_n(link.io_read_n),
    .io_write_n(link.io_write_n), .aen(link.aen), .refresh_cycle_n(link.refresh_cycle_n),
    .bus_reset(link.bus_reset), .memcs16_o(link.memcs16_o), .memcs16_oe(link.memcs16_oe),
    .dev_data_oe(link.dev_data_oe), .rdy_o(link.rdy_o), .rdy_oe(link.rdy_oe));

  always #12.5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run;
    end
  end

  // display memory answers after a random 1..4 cycle delay
  always @(posedge core_clk) begin
    if (mem_req === 1'b1) begin
      reqs++;
      ack_wait <= 1 + ($random(seed) & 3);
    end else if (ack_wait > 0) begin
      ack_wait <= ack_wait - 1;
    end
    // one assignment per edge: ack is a single-cycle pulse with its data
    mem_ack <= (ack_wait == 1);
    if (ack_wait == 1) mem_rdata <= 16'($random(seed));
  end

  function automatic logic win(input logic [UPPER_W-1:0] a);
    win = !a[6] && !a[5] && !a[4] && !a[3] && a[2] && !a[1] && a[0];
  endfunction

  task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // k: 0 memory read, 1 memory write, 2 io read, 3 io write
  task automatic bus_cycle(input logic [1:0] c, input logic [UPPER_W-1:0] a_la,
      input logic [ADDR_W-1:0] a_sa, input logic [DATA_W-1:0] a_wd, input logic a_aen,
      input logic a_rf);
    int n;
    @(posedge core_clk);
    host_la <= a_la;
    host_sa <= a_sa;
    host_wdata <= a_wd;
    host_aen <= a_aen;
    host_refresh_n <= a_rf;
    host_wdata_oe <= c[0];
    host_bhe_n <= 1'($random(seed));
    host_mem_read_n <= (c != 2'd0);
    host_mem_write_n <= (c != 2'd1);
    host_io_read_n <= (c != 2'd2);
    host_io_write_n <= (c != 2'd3);
    took = 1'b0;
    wt = 1'b0;
    seen = 'x;
    // the request is held until ready is seen high, so the release lands after it
    for (n = 0; n < 40 && !took; n++) begin
      @(negedge core_clk);
      if (link.dev_data_oe === 1'b1) seen = link.data;
      qsel = !(link.qualified_mem_read_n && link.qualified_mem_write_n);
      csel = host_memcs16;
      hr = host_rdata;
      if (host_ready === 1'b0) wt = 1'b1;
      took = (link.rdy_oe === 1'b1) && (link.rdy_o === 1'b1);
    end
    @(posedge core_clk);
    host_mem_read_n <= 1'b1;
    host_mem_write_n <= 1'b1;
    host_io_read_n <= 1'b1;
    host_io_write_n <= 1'b1;
    host_wdata_oe <= 1'b0;
    host_aen <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask

  task automatic pulse_vsync;
    @(posedge core_clk);
    vsync <= 1'b1;
    repeat (3) @(posedge core_clk);
    vsync <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic complete_run;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    core_clk = 0;
    rstn = 0;
    vsync = 0;
    host_reset = 0;
    host_la = 0;
    host_sa = 0;
    host_wdata = 0;
    host_wdata_oe = 0;
    host_aen = 1;
    host_bhe_n = 1;
    host_refresh_n = 1;
    {host_mem_read_n, host_mem_write_n, host_io_read_n, host_io_write_n} = 4'hf;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (i = 0; i < 30; i++) begin
      k = {1'b0, 1'($random(seed))};
      la = (i < 3) ? 7'h04 + 7'(i) : ((i % 3 == 0) ? 7'($random(seed)) : 7'h05);
      sa = 17'($random(seed));
      wd = 16'($random(seed));
      rf = (i % 4 != 3);
      r0 = reqs;
      bus_cycle(k, la, sa, wd, 1'b1, rf);
      check_val("window select", 32'(win(la)), 32'(qsel));
      check_val("memcs16", 32'(win(la)), 32'(csel));
      check_val("requests", 32'(win(la) && rf), 32'(reqs - r0));
      check_val("cycle ended", 32'(win(la) && rf), 32'(took));
      check_val("ready waited", 32'(win(la) && rf), 32'(wt));
      check_val("ready idle", 32'h1, 32'(host_ready));
      if (win(la) && rf) begin
        check_val("address", 32'(sa), 32'(mem_addr));
        check_val("byte lanes", 32'({~host_bhe_n, ~sa[0]}), 32'(mem_be));
        check_val("write flag", 32'(k[0]), 32'(mem_we));
        if (k[0]) check_val("write data", 32'(wd), 32'(mem_wdata));
        else begin
          check_val("read data", 32'(mem_rdata), 32'(seen));
          check_val("host read data", 32'(mem_rdata), 32'(hr));
        end
      end
    end
    pulse_vsync;
    check_val("irq disabled", 32'h0, 32'(host_irq));
    bus_cycle(2'd3, 7'h00, PORT_IRQ_CTRL, 16'h0003, 1'b0, 1'b1);
    check_val("io taken", 32'h1, 32'(took));
    pulse_vsync;
    check_val("irq raised", 32'h1, 32'(host_irq));
    bus_cycle(2'd3, 7'h00, PORT_IRQ_CTRL, 16'h0001, 1'b1, 1'b1);
    check_val("io ignored", 32'h0, 32'(took));
    check_val("irq kept", 32'h1, 32'(host_irq));
    bus_cycle(2'd3, 7'h00, PORT_IRQ_CTRL, 16'h0001, 1'b0, 1'b1);
    check_val("irq low polarity", 32'h0, 32'(host_irq));
    bus_cycle(2'd3, 7'h00, PORT_TIM_INDEX, 16'(TIM_IDX_VRETRACE_END), 1'b0, 1'b1);
    bus_cycle(2'd3, 7'h00, PORT_TIM_DATA, 16'h005a, 1'b0, 1'b1);
    check_val("irq cleared", 32'h1, 32'(host_irq));
    bus_cycle(2'd2, 7'h00, PORT_TIM_DATA, 16'h0000, 1'b0, 1'b1);
    check_val("timing readback", 32'h5a, 32'(seen[7:0]));
    check_val("host timing readback", 32'h5a, 32'(hr[7:0]));
    bus_cycle(2'd3, 7'h00, 17'h003d0, 16'h0001, 1'b0, 1'b1);
    check_val("unmapped io", 32'h0, 32'(took));
    @(posedge core_clk);
    host_reset <= 1'b1;
    repeat (4) @(posedge core_clk);
    check_val("serial enable in reset", 32'h1, 32'(vram_serial_oe_n));
    check_val("irq after reset", 32'h0, 32'(host_irq));
    host_reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    check_val("serial enable", 32'h0, 32'(vram_serial_oe_n));
    bus_cycle(2'd2, 7'h00, PORT_IRQ_CTRL, 16'h0000, 1'b0, 1'b1);
    check_val("irq control after reset", 32'(IRQ_CTRL_RESET), 32'(hr[7:0]));
    complete_run;
  end
endmodule // isa_host_bus_slave_port_bench
